// *** bench/sre_board.sv ***
// Board reset logic with pull-up on the system reset line
`timescale 1ns/100ps
`default_nettype none
module sre_board (
	// Clock
	input  wire logic       core_clk_i,
	// Control
	input  wire logic [7:0] low_cyc_i,
	input  wire logic       go_i,
	input  wire logic       dev_oe_i,
	// Wire level
	output logic            line_o
);
	logic [7:0] cnt_q;
	always_ff @(posedge core_clk_i) begin
		if (go_i)
			cnt_q <= low_cyc_i;
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end
	// Pull-up wins unless a party pulls low
	assign line_o = !(dev_oe_i || cnt_q != 8'h00);
endmodule
`default_nettype wire

// *** bench/test_system_reset_error_pins.sv ***
// Testbench of the system reset and error pin block
`timescale 1ns/100ps
`default_nettype none
module test_system_reset_error_pins;
	logic clk, rst_n, ex, be, clr, swr, ten, go, oe, lo, rl, sro, mce;
	logic [7:0] lc;
	logic [63:0] sel, fo, gd, po;
	sre_pkg::sre_test_s traw, tg;
	int num_errors, n_checks, cyc, n;
	sre_top #(.RST_MIN_CYC(4), .RST_OUT_CYC(4)) sre_top_inst (
		.core_clk_i(clk), .rst_n_i(rst_n), .fetch_exec_i(ex), .fetch_bus_err_i(be),
		.syndrome_mc_clear_i(clr), .machine_check_error_out_o(mce), .sw_reset_req_i(swr),
		.system_reset_line_i(rl), .system_reset_line_o(lo), .system_reset_line_oe_o(oe),
		.system_reset_o(sro), .manufacturing_test_enable_i(ten), .test_raw_i(traw),
		.test_gated_o(tg), .gpio_sel_i(sel), .func_out_i(fo), .gpio_out_i(gd),
		.pin_out_o(po));
	sre_board sre_board_inst (.core_clk_i(clk), .low_cyc_i(lc), .go_i(go),
		.dev_oe_i(oe), .line_o(rl));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic cmp(string nm, logic [63:0] e, logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk_error;
		ex = 1;
		tick(1);
		cmp("err_no_bus_err", 0, mce);
		be = 1;
		tick(1);
		{ex, be} = 2'h0;
		cmp("err_set", 1, mce);
		tick(3);
		cmp("err_hold", 1, mce);
		{clr, ex, be} = 3'h7;
		tick(1);
		{ex, be} = 2'h0;
		cmp("err_set_wins", 1, mce);
		tick(1);
		clr = 0;
		cmp("err_clear", 0, mce);
	endtask
	task automatic pulse(logic [7:0] k);
		lc = k;
		go = 1;
		tick(1);
		go = 0;
	endtask
	task automatic chk_ext;
		pulse(8'h03);
		tick(12);
		cmp("short_low", 0, sro);
		pulse(8'h0c);
		n = 0;
		while (sro !== 1'b1 && n < 30) begin
			tick(1);
			n++;
		end
		cmp("ext_delay", 1, n inside {[4:12]});
		tick(20);
		cmp("ext_end", 0, sro);
	endtask
	task automatic chk_sw;
		swr = 1;
		tick(1);
		swr = 0;
		cmp("sw_oe", 1, oe);
		cmp("sw_data", 0, lo);
		cmp("sw_wire", 0, rl);
		tick(1);
		cmp("sw_rst", 1, sro);
		tick(3);
		cmp("sw_release", 0, oe);
		tick(10);
		cmp("sw_end", 0, sro);
	endtask
	task automatic chk_test;
		traw = 6'h3f;
		tick(6);
		cmp("test_off", 0, tg);
		ten = 1;
		tick(6);
		cmp("test_on", 6'h3f, tg);
		traw = 6'h15;
		tick(1);
		cmp("test_pass", 6'h15, tg);
		ten = 0;
	endtask
	task automatic chk_gpio;
		sel = 64'h0000_0000_ffff_0000;
		fo = {16{4'ha}};
		gd = {16{4'h5}};
		tick(1);
		cmp("pin_mux", (gd & sel) | (fo & ~sel), po);
	endtask
	initial begin
		{rst_n, ex, be, clr, swr, ten, go} = 7'h01;
		{lc, traw, sel, fo, gd} = '0;
		{num_errors, n_checks, cyc} = '0;
		tick(8);
		rst_n = 1;
		go = 0;
		chk_error();
		chk_ext();
		chk_sw();
		chk_test();
		chk_gpio();
		give_verdict();
	end
endmodule
`default_nettype wire

// *** verilog/sre_cfg.svh ***
// Constants for the system reset and error pin block
`ifndef SRE_CFG_SVH
`define SRE_CFG_SVH
`define SRE_RST_MIN_CYC     16
`define SRE_RST_OUT_CYC     16
`define SRE_GPIO_W          64
`define SRE_TEST_W          6
`define SRE_SYNC_RESET_VAL  1'b1
`endif

// *** verilog/sre_pkg.sv ***
// Types for the system reset and error pin block
`default_nettype none
package sre_pkg;
	typedef struct packed {
		logic receiver_inhibit;
		logic test_mode_control;
		logic leakage_test;
		logic reference_enable;
		logic driver_inhibit_first;
		logic driver_inhibit_second;
	} sre_test_s;
	typedef enum logic [1:0] {
		SRE_IDLE,
		SRE_DRIVE,
		SRE_RELEASE
	} sre_rst_e;
endpackage
`default_nettype wire

// *** verilog/sre_sync3.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sre_sync3 #(
	parameter logic INIT = 1'b1
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	// Pin side
	input  wire logic async_i,
	// Core side
	output logic      level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level changes only once the last two stages agree
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			level_o <= INIT;
		end else if (s2_q == s3_q) begin
			level_o <= s3_q;
		end
	end
endmodule
`default_nettype wire

// *** verilog/sre_top.sv ***
// System reset line, machine-check error output and test gating
`timescale 1ns/100ps
`default_nettype none
`include "sre_cfg.svh"
// Function
// - Error output goes 1 on machine check
// - Check means fetch with bus error executed
// - Error holds until syndrome bit cleared
// - Software may request system reset too
// - Reset line open drain, never driven high
// - Test inputs ignored without test enable
// - General IO only after control bits set
module sre_top #(
	parameter int RST_MIN_CYC = `SRE_RST_MIN_CYC,
	parameter int RST_OUT_CYC = `SRE_RST_OUT_CYC,
	parameter int GPIO_W      = `SRE_GPIO_W
) (
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_n_i,
	// Core fetch and exception syndrome
	input  wire logic              fetch_exec_i,
	input  wire logic              fetch_bus_err_i,
	input  wire logic              syndrome_mc_clear_i,
	output logic                   machine_check_error_out_o,
	// Software reset request
	input  wire logic              sw_reset_req_i,
	// System reset line, open drain
	input  wire logic              system_reset_line_i,
	output logic                   system_reset_line_o,
	output logic                   system_reset_line_oe_o,
	output logic                   system_reset_o,
	// Manufacturing test inputs
	input  wire logic              manufacturing_test_enable_i,
	input  wire sre_pkg::sre_test_s test_raw_i,
	output var sre_pkg::sre_test_s test_gated_o,
	// General IO muxing
	input  wire logic [GPIO_W-1:0] gpio_sel_i,
	input  wire logic [GPIO_W-1:0] func_out_i,
	input  wire logic [GPIO_W-1:0] gpio_out_i,
	output logic [GPIO_W-1:0]      pin_out_o
);
	localparam int CW = $clog2(RST_MIN_CYC + RST_OUT_CYC + 1);

	logic              err_q;
	logic              line_lvl;
	logic              ten_lvl;
	logic [CW-1:0]     low_cnt_q;
	logic [CW-1:0]     out_cnt_q;
	logic              sys_rst_q;
	sre_pkg::sre_rst_e st_q;
	sre_pkg::sre_test_s test_q;
	logic [GPIO_W-1:0] pin_q;

	// Machine check: a fetched instruction with a bus error is executed
	wire mc_event = fetch_exec_i & fetch_bus_err_i;

	// Error flag; a new check wins over a clear in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			err_q <= 1'b0;
		end else if (mc_event) begin
			err_q <= 1'b1;
		end else if (syndrome_mc_clear_i) begin
			err_q <= 1'b0;
		end
	end
	assign machine_check_error_out_o = err_q;

	sre_sync3 #(
		.INIT (`SRE_SYNC_RESET_VAL)
	) u_line_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (system_reset_line_i),
		.level_o    (line_lvl)
	);

	sre_sync3 #(
		.INIT (1'b0)
	) u_ten_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (manufacturing_test_enable_i),
		.level_o    (ten_lvl)
	);

	// Count consecutive low cycles of the line seen from outside
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			low_cnt_q <= '0;
		end else if (line_lvl || st_q != sre_pkg::SRE_IDLE) begin
			low_cnt_q <= '0;
		end else if (low_cnt_q != CW'(RST_MIN_CYC)) begin
			low_cnt_q <= low_cnt_q + 1'b1;
		end
	end

	// Reset sequencer: software request drives the line low itself
	// The drive must outlast the line sync delay, or release sees a stale high
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			st_q      <= sre_pkg::SRE_IDLE;
			out_cnt_q <= '0;
			sys_rst_q <= 1'b0;
		end else begin
			unique case (st_q)
				sre_pkg::SRE_IDLE: begin
					sys_rst_q <= 1'b0;
					if (sw_reset_req_i) begin
						st_q      <= sre_pkg::SRE_DRIVE;
						out_cnt_q <= '0;
					end else if (low_cnt_q == CW'(RST_MIN_CYC)) begin
						sys_rst_q <= 1'b1;
						st_q      <= sre_pkg::SRE_RELEASE;
					end
				end
				sre_pkg::SRE_DRIVE: begin
					sys_rst_q <= 1'b1;
					out_cnt_q <= out_cnt_q + 1'b1;
					if (out_cnt_q == CW'(RST_OUT_CYC - 1)) begin
						st_q <= sre_pkg::SRE_RELEASE;
					end
				end
				sre_pkg::SRE_RELEASE: begin
					if (line_lvl) begin
						st_q      <= sre_pkg::SRE_IDLE;
						sys_rst_q <= 1'b0;
					end
				end
			endcase
		end
	end

	// Open drain: output data fixed low, only the enable toggles
	assign system_reset_line_o    = 1'b0;
	assign system_reset_line_oe_o = (st_q == sre_pkg::SRE_DRIVE);
	assign system_reset_o         = sys_rst_q;

	// Test inputs pass only while test enable is active
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			test_q <= '0;
		end else begin
			test_q <= ten_lvl ? test_raw_i : '0;
		end
	end
	assign test_gated_o = test_q;

	// Each pin takes general IO data only when its select bit is set
	genvar g;
	generate
		for (g = 0; g < GPIO_W; g++) begin : g_pin
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					pin_q[g] <= 1'b0;
				end else begin
					pin_q[g] <= gpio_sel_i[g] ? gpio_out_i[g] : func_out_i[g];
				end
			end
			gpio_take_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
				gpio_sel_i[g] |=> pin_out_o[g] == $past(gpio_out_i[g]))
				else $error("general IO data not taken with select");
		end
	endgenerate
	assign pin_out_o = pin_q;

	// Error output tracks its cause
	mc_sets_err_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		mc_event |=> machine_check_error_out_o)
		else $error("error output not set after machine check");
	err_holds_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		machine_check_error_out_o && !syndrome_mc_clear_i |=> machine_check_error_out_o)
		else $error("error output dropped without clear");
	err_clears_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		syndrome_mc_clear_i && !mc_event |=> !machine_check_error_out_o)
		else $error("error output not cleared");
	err_cause_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(machine_check_error_out_o) |-> $past(fetch_exec_i && fetch_bus_err_i))
		else $error("error output rose without bus error fetch");
	line_never_high_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		system_reset_line_oe_o |-> !system_reset_line_o)
		else $error("reset line driven high");

	// Software drive lasts exactly the configured count
	sw_drive_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		st_q == sre_pkg::SRE_IDLE && sw_reset_req_i |=> system_reset_line_oe_o)
		else $error("software reset not driven");
	sw_drive_len_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$fell(system_reset_line_oe_o) |-> $past(out_cnt_q) == CW'(RST_OUT_CYC - 1))
		else $error("software reset drive length wrong");
	oe_bound_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		system_reset_line_oe_o |-> out_cnt_q < CW'(RST_OUT_CYC))
		else $error("software reset drive overran");
	sw_rst_follows_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(system_reset_line_oe_o) |=> system_reset_o)
		else $error("software reset did not reset the system");
	rst_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		st_q == sre_pkg::SRE_RELEASE && !line_lvl |=> system_reset_o)
		else $error("system reset dropped while line low");
	rst_release_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		st_q == sre_pkg::SRE_RELEASE && line_lvl |=> !system_reset_o)
		else $error("system reset held after line high");

	// External reset only after the full minimum low time
	ext_rst_min_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(system_reset_o) && !system_reset_line_oe_o |->
			$past(low_cnt_q) == CW'(RST_MIN_CYC))
		else $error("external reset taken before minimum");
	ext_short_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		st_q == sre_pkg::SRE_IDLE && !sw_reset_req_i && low_cnt_q != CW'(RST_MIN_CYC)
			|=> !system_reset_o)
		else $error("system reset from short low pulse");

	// Test and general IO gating
	test_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!ten_lvl |=> test_gated_o == '0)
		else $error("test input passed without test enable");
	test_pass_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		ten_lvl |=> test_gated_o == $past(test_raw_i))
		else $error("test input not passed with test enable");
	gpio_sel_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!gpio_sel_i[0] |=> pin_out_o[0] == $past(func_out_i[0]))
		else $error("general IO active without select");
endmodule
`default_nettype wire
